// ### inc/can_front_defs.svh
// Constants of the CAN message object front end: offsets, fields, resets, timing.
// Assumes a 32-bit Avalon-MM slave, one word per register, byte addresses.
`ifndef CAN_FRONT_DEFS_SVH
`define CAN_FRONT_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STAT 8'h08
`define OFF_IRQ_MASK 8'h0c
`define OFF_OBJ_SEL 8'h10
`define OFF_OBJ_ID 8'h14
`define OFF_OBJ_CMD 8'h18
`define OFF_FETCH 8'h1c
`define OFF_RATE 8'h20
`define OFF_CLKOUT 8'h24
`define OFF_BUSCFG 8'h28
`define OFF_FILTER 8'h2c
`define OFF_BUF 8'h40
`define OFF_RAW 12'h400
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CTRL_INIT 0
`define CMD_EN_RX 0
`define CMD_EN_TX 1
`define CMD_EN_EVT 2
`define CMD_IDLEN 3
`define CMD_SEND 4
`define CMD_DISABLE 5
`define FETCH_CONSIST 0
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RATE_DEFAULT_KBPS 16'd1000
`define FILTER_MUST_MATCH 32'hffff_ffff
`define INIT_RESET_NS 40
`define CLK_PERIOD_NS 4
`define INIT_RESET_CYC ((`INIT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NUM_OBJ 16
`define RX_OBJ_MAX 15
`define TX_OBJ_MAX 14
`define BUF_ENTRIES 9
`define FETCH_NONE 32'hffff_ffff
`endif

// ### inc/can_front_pkg.sv
// Types of the CAN message object front end.
// Assumes can_front_defs.svh for numeric constants.
package can_front_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_COPY} fe_state_type;
    typedef logic [7:0] byte_type;
endpackage

// ### src/can_front.sv
// CAN message object front end: registers, object table, fetch and send.
// Assumes an external frame engine delivers whole frames and arbitrates the bus.
`include "can_front_defs.svh"

// Function
// - Nine-entry buffer: eight payload bytes plus a length of zero to eight.
// - Every buffer entry is eight bits wide.
// - Objects one to fifteen with events enabled raise an event per arrival.
// - An object accepts frames only after receive enable.
// - Receive objects store only frames whose identifier matches in every bit set in the filter.
// - Objects one to fourteen send only after enable, with their identifier.
// - Length select zero gives 11-bit, one gives 29-bit identifiers.
// - Raw registers 0 to 255 readable, byte in low bits.
// - Init resets controller, filters must-match, clockout and bus config zero.
// - Init programs the default bit rate of 1 MBit/s.
// - Init disables every object for receive and send.
// - Fetch returns -1 with nothing new, else copies frame and returns identifier.
// - A fetched frame is reported only once until another arrives.
// - Consistent fetch reports only complete frames.
// - Consistent fetch buffer holds old or new frame, never a mix.
// - A send request goes on the bus once the object wins access.
module can_front (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    input wire logic rx_valid_i,
    input wire logic [28:0] rx_id_i,
    input wire logic rx_ext_i,
    input wire logic [3:0] rx_len_i,
    input wire logic [63:0] rx_data_i,
    output logic tx_req_o,
    output logic [3:0] tx_obj_o,
    output logic [28:0] tx_id_o,
    output logic tx_ext_o,
    output logic [3:0] tx_len_o,
    output logic [63:0] tx_data_o,
    input wire logic tx_grant_i,
    output logic ctrl_rst_o,
    output logic [15:0] rate_kbps_o,
    output logic [7:0] clkout_o,
    output logic [7:0] buscfg_o
);
    import can_front_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    can_front_pkg::fe_state_type state_ff, nxt_state;
    logic [15:0] rx_en_ff, nxt_rx_en, tx_en_ff, nxt_tx_en, evt_en_ff, nxt_evt_en, ext_ff, nxt_ext;
    logic [15:0] new_ff, nxt_new, irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask, rate_ff, nxt_rate;
    logic [28:0] id_ff [`NUM_OBJ], nxt_id [`NUM_OBJ], fid_ff [`NUM_OBJ], nxt_fid [`NUM_OBJ];
    logic [3:0] flen_ff [`NUM_OBJ], nxt_flen [`NUM_OBJ];
    logic [63:0] fdat_ff [`NUM_OBJ], nxt_fdat [`NUM_OBJ], tx_data_ff, nxt_tx_data;
    byte_type buf_ff [`BUF_ENTRIES], nxt_buf [`BUF_ENTRIES], raw_ff [256], nxt_raw_wd;
    logic [3:0] sel_ff, nxt_sel, cobj_ff, nxt_cobj, tx_obj_ff, nxt_tx_obj, tx_len_ff, nxt_tx_len, rx_hit;
    logic [31:0] filter_ff, nxt_filter, rdata_ff, nxt_rdata, wd;
    logic [28:0] tx_id_ff, nxt_tx_id, rx_idm;
    logic [7:0] cnt_ff, nxt_cnt, clkout_ff, nxt_clkout, buscfg_ff, nxt_buscfg;
    logic wait_ff, nxt_wait, irq_ff, tx_req_ff, nxt_tx_req, tx_ext_ff, nxt_tx_ext, ctrl_rst_ff, nxt_ctrl_rst;
    logic raw_we, rx_found, req, req_wr;

    assign req = (avs_read_i | avs_write_i) & wait_ff & (state_ff == ST_IDLE);
    assign req_wr = req & avs_write_i;
    assign wd = avs_writedata_i;

    // ----------------------------------------------------------------
    // Receive match: lowest enabled object with identifier equal in the filter bits
    // ----------------------------------------------------------------
    always_comb begin
        rx_hit = 4'h0;
        rx_found = 1'b0;
        rx_idm = rx_ext_i ? rx_id_i : {18'h0, rx_id_i[10:0]};
        for (int k = `RX_OBJ_MAX; k >= 1; k--) begin
            if (rx_en_ff[k] && ext_ff[k] == rx_ext_i &&
                ((id_ff[k] ^ rx_idm) & filter_ff[28:0]) == 29'h0) begin
                rx_hit = k[3:0];
                rx_found = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Next state: bus slave, object table, fetch copy, send
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_rx_en = rx_en_ff;
        nxt_tx_en = tx_en_ff;
        nxt_evt_en = evt_en_ff;
        nxt_ext = ext_ff;
        nxt_new = new_ff;
        nxt_id = id_ff;
        nxt_fid = fid_ff;
        nxt_flen = flen_ff;
        nxt_fdat = fdat_ff;
        nxt_buf = buf_ff;
        nxt_sel = sel_ff;
        nxt_filter = filter_ff;
        nxt_irq_stat = irq_stat_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_cnt = cnt_ff;
        nxt_cobj = cobj_ff;
        nxt_rdata = rdata_ff;
        nxt_wait = 1'b1;
        nxt_tx_req = tx_req_ff;
        nxt_tx_obj = tx_obj_ff;
        nxt_tx_id = tx_id_ff;
        nxt_tx_ext = tx_ext_ff;
        nxt_tx_len = tx_len_ff;
        nxt_tx_data = tx_data_ff;
        nxt_ctrl_rst = ctrl_rst_ff;
        nxt_rate = rate_ff;
        nxt_clkout = clkout_ff;
        nxt_buscfg = buscfg_ff;
        raw_we = 1'b0;
        nxt_raw_wd = wd[7:0];
        // Send request is dropped once the bus is granted
        if (tx_grant_i && tx_req_ff) begin
            nxt_tx_req = 1'b0;
        end
        // Software bus access, one wait state then answer
        if (req) begin
            nxt_wait = 1'b0;
            nxt_rdata = 32'h0;
            if (avs_address_i >= `OFF_RAW) begin
                raw_we = avs_write_i & avs_byteenable_i[0];
                nxt_rdata = {24'h0, raw_ff[avs_address_i[9:2]]};
            end else if (avs_address_i >= `OFF_BUF &&
                         avs_address_i < `OFF_BUF + 4 * `BUF_ENTRIES) begin
                if (req_wr && avs_byteenable_i[0]) begin
                    nxt_buf[avs_address_i[5:2]] = wd[7:0];
                end
                nxt_rdata = {24'h0, buf_ff[avs_address_i[5:2]]};
            end else begin
                case (avs_address_i[7:0])
                `OFF_CTRL: begin
                    if (req_wr && wd[`CTRL_INIT]) begin
                        nxt_state = ST_INIT;
                        nxt_cnt = 8'(`INIT_RESET_CYC);
                        nxt_ctrl_rst = 1'b1;
                    end
                end
                `OFF_STATUS: nxt_rdata = {16'h0, new_ff};
                `OFF_IRQ_STAT: begin
                    nxt_irq_stat = req_wr ? irq_stat_ff & ~wd[15:0] : irq_stat_ff;
                    nxt_rdata = {16'h0, irq_stat_ff};
                end
                `OFF_IRQ_MASK: begin
                    nxt_irq_mask = req_wr ? wd[15:0] : irq_mask_ff;
                    nxt_rdata = {16'h0, irq_mask_ff};
                end
                `OFF_OBJ_SEL: begin
                    nxt_sel = req_wr ? wd[3:0] : sel_ff;
                    nxt_rdata = {28'h0, sel_ff};
                end
                `OFF_OBJ_ID: begin
                    nxt_id[sel_ff] = req_wr ? wd[28:0] : id_ff[sel_ff];
                    nxt_rdata = {3'h0, id_ff[sel_ff]};
                end
                `OFF_OBJ_CMD: begin
                    if (req_wr && sel_ff != 4'h0) begin
                        if (wd[`CMD_DISABLE]) begin
                            nxt_rx_en[sel_ff] = 1'b0;
                            nxt_tx_en[sel_ff] = 1'b0;
                        end
                        if (wd[`CMD_EN_RX] && sel_ff <= `RX_OBJ_MAX) begin
                            nxt_rx_en[sel_ff] = 1'b1;
                            nxt_ext[sel_ff] = wd[`CMD_IDLEN];
                        end
                        if (wd[`CMD_EN_TX] && sel_ff <= `TX_OBJ_MAX) begin
                            nxt_tx_en[sel_ff] = 1'b1;
                            nxt_ext[sel_ff] = wd[`CMD_IDLEN];
                        end
                        if (wd[`CMD_EN_EVT] && sel_ff <= `RX_OBJ_MAX) begin
                            nxt_evt_en[sel_ff] = 1'b1;
                        end
                        if (wd[`CMD_SEND] && tx_en_ff[sel_ff] && !tx_req_ff) begin
                            nxt_tx_req = 1'b1;
                            nxt_tx_obj = sel_ff;
                            nxt_tx_ext = ext_ff[sel_ff];
                            nxt_tx_id = ext_ff[sel_ff] ? id_ff[sel_ff] : {18'h0, id_ff[sel_ff][10:0]};
                            nxt_tx_len = (buf_ff[8] > 8'h08) ? 4'h8 : buf_ff[8][3:0];
                            for (int b = 0; b < 8; b++) begin
                                nxt_tx_data[8 * b +: 8] = buf_ff[b];
                            end
                        end
                    end
                    nxt_rdata = {27'h0, ext_ff[sel_ff], 1'b0, evt_en_ff[sel_ff],
                                 tx_en_ff[sel_ff], rx_en_ff[sel_ff]};
                end
                `OFF_FETCH: begin
                    // Answer withheld until the copy is done
                    if (req_wr || sel_ff == 4'h0 || sel_ff > `RX_OBJ_MAX || !new_ff[sel_ff]) begin
                        nxt_rdata = `FETCH_NONE;
                    end else begin
                        nxt_wait = 1'b1;
                        nxt_state = ST_COPY;
                        nxt_cobj = sel_ff;
                    end
                end
                `OFF_RATE: begin
                    nxt_rate = req_wr ? wd[15:0] : rate_ff;
                    nxt_rdata = {16'h0, rate_ff};
                end
                `OFF_CLKOUT: begin
                    nxt_clkout = req_wr ? wd[7:0] : clkout_ff;
                    nxt_rdata = {24'h0, clkout_ff};
                end
                `OFF_BUSCFG: begin
                    nxt_buscfg = req_wr ? wd[7:0] : buscfg_ff;
                    nxt_rdata = {24'h0, buscfg_ff};
                end
                `OFF_FILTER: begin
                    nxt_filter = req_wr ? wd : filter_ff;
                    nxt_rdata = filter_ff;
                end
                default: nxt_rdata = 32'h0;
                endcase
            end
        end
        case (state_ff)
        ST_INIT: begin
            nxt_rx_en = 16'h0;
            nxt_tx_en = 16'h0;
            nxt_evt_en = 16'h0;
            nxt_new = 16'h0;
            nxt_tx_req = 1'b0;
            nxt_filter = `FILTER_MUST_MATCH;
            nxt_clkout = 8'h00;
            nxt_buscfg = 8'h00;
            nxt_rate = `RATE_DEFAULT_KBPS;
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff <= 8'h01) begin
                nxt_ctrl_rst = 1'b0;
                nxt_state = ST_IDLE;
            end
        end
        ST_COPY: begin
            // Single-cycle snapshot of one stored frame: never a mix
            for (int b = 0; b < 8; b++) begin
                nxt_buf[b] = fdat_ff[cobj_ff][8 * b +: 8];
            end
            nxt_buf[8] = {4'h0, flen_ff[cobj_ff]};
            nxt_new[cobj_ff] = 1'b0;
            nxt_rdata = {3'h0, fid_ff[cobj_ff]};
            nxt_wait = 1'b0;
            nxt_state = ST_IDLE;
        end
        ST_IDLE: ;
        default: nxt_state = ST_IDLE;
        endcase
        // Arrival of a whole frame wins over a clear in the same cycle
        if (rx_valid_i && rx_found && state_ff != ST_INIT) begin
            nxt_fid[rx_hit] = rx_idm;
            nxt_flen[rx_hit] = (rx_len_i > 4'h8) ? 4'h8 : rx_len_i;
            nxt_fdat[rx_hit] = rx_data_i;
            nxt_new[rx_hit] = 1'b1;
            if (evt_en_ff[rx_hit]) begin
                nxt_irq_stat[rx_hit] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= ST_IDLE;
            {rx_en_ff, tx_en_ff, evt_en_ff, ext_ff, new_ff, irq_stat_ff, irq_mask_ff} <= 112'h0;
            for (int i = 0; i < `NUM_OBJ; i++) begin
                id_ff[i] <= 29'h0;
                fid_ff[i] <= 29'h0;
                flen_ff[i] <= 4'h0;
                fdat_ff[i] <= 64'h0;
            end
            for (int i = 0; i < `BUF_ENTRIES; i++) begin
                buf_ff[i] <= 8'h00;
            end
            {sel_ff, cnt_ff, cobj_ff, rdata_ff} <= 48'h0;
            filter_ff <= `FILTER_MUST_MATCH;
            wait_ff <= 1'b1;
            {tx_req_ff, tx_obj_ff, tx_id_ff, tx_ext_ff, tx_len_ff, tx_data_ff} <= 103'h0;
            {irq_ff, ctrl_rst_ff, clkout_ff, buscfg_ff} <= 18'h0;
            rate_ff <= `RATE_DEFAULT_KBPS;
        end else begin
            state_ff <= nxt_state;
            {rx_en_ff, tx_en_ff, evt_en_ff, ext_ff, new_ff} <=
                {nxt_rx_en, nxt_tx_en, nxt_evt_en, nxt_ext, nxt_new};
            id_ff <= nxt_id;
            fid_ff <= nxt_fid;
            flen_ff <= nxt_flen;
            fdat_ff <= nxt_fdat;
            buf_ff <= nxt_buf;
            sel_ff <= nxt_sel;
            filter_ff <= nxt_filter;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            cnt_ff <= nxt_cnt;
            cobj_ff <= nxt_cobj;
            rdata_ff <= nxt_rdata;
            wait_ff <= nxt_wait;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
            {tx_req_ff, tx_obj_ff, tx_id_ff, tx_ext_ff, tx_len_ff, tx_data_ff} <=
                {nxt_tx_req, nxt_tx_obj, nxt_tx_id, nxt_tx_ext, nxt_tx_len, nxt_tx_data};
            ctrl_rst_ff <= nxt_ctrl_rst;
            rate_ff <= nxt_rate;
            clkout_ff <= nxt_clkout;
            buscfg_ff <= nxt_buscfg;
        end
    end

    // Raw register image, no reset: plain memory
    always_ff @(posedge clk_i) begin
        if (raw_we) begin
            raw_ff[avs_address_i[9:2]] <= nxt_raw_wd;
        end
    end

    // Outputs straight from registers, no logic behind them
    assign {avs_readdata_o, avs_waitrequest_o, irq_o, tx_req_o, tx_obj_o, tx_id_o, tx_ext_o} =
        {rdata_ff, wait_ff, irq_ff, tx_req_ff, tx_obj_ff, tx_id_ff, tx_ext_ff};
    assign {tx_len_o, tx_data_o, ctrl_rst_o, rate_kbps_o, clkout_o, buscfg_o} =
        {tx_len_ff, tx_data_ff, ctrl_rst_ff, rate_ff, clkout_ff, buscfg_ff};
endmodule // can_front

// ### test/can_front_chk.sv
// Port checker of the CAN front end, bound to every instance.
// Assumes one clock domain and the offsets of can_front_defs.svh.
`include "can_front_defs.svh"
module can_front_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic tx_req_o,
    input wire logic [28:0] tx_id_o,
    input wire logic [3:0] tx_len_o,
    input wire logic [63:0] tx_data_o,
    input wire logic tx_grant_i,
    input wire logic ctrl_rst_o,
    input wire logic [15:0] rate_kbps_o,
    input wire logic [7:0] clkout_o,
    input wire logic [7:0] buscfg_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------------------------------
    // Bus answers, init pulse and send handshake
    // ----------------------------------------------------------------
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held longer than one cycle");
    tx_cause_a: assert property ($rose(tx_req_o) |-> $past(avs_write_i) && $past(avs_address_i) == `OFF_OBJ_CMD)
        else $error("send without command write");
    tx_hold_a: assert property (tx_req_o && !tx_grant_i |=> tx_req_o && $stable(tx_id_o) && $stable(tx_data_o))
        else $error("send request dropped or changed before grant");
    tx_drop_a: assert property (tx_req_o && tx_grant_i |=> !tx_req_o)
        else $error("send request kept after grant");
    // Payload length is a byte count, never above eight
    tx_len_a: assert property (tx_req_o |-> tx_len_o <= 4'd8)
        else $error("send length above eight");
    // Ten cycles of controller reset, counted by repetition
    init_len_a: assert property ($rose(ctrl_rst_o) |-> ctrl_rst_o [*8] ##1 ctrl_rst_o ##1 ctrl_rst_o ##1 !ctrl_rst_o)
        else $error("controller reset pulse length wrong");
    init_vals_a: assert property ($fell(ctrl_rst_o) |-> rate_kbps_o == `RATE_DEFAULT_KBPS && (clkout_o | buscfg_o) == 8'h00)
        else $error("init left wrong rate or config");
    init_quiet_a: assert property (ctrl_rst_o |-> !tx_req_o)
        else $error("send request during init");
endmodule // can_front_chk

bind can_front can_front_chk u_can_front_chk (.clk_i, .sys_rst_i, .avs_address_i, .avs_write_i,
    .avs_waitrequest_o, .tx_req_o, .tx_id_o, .tx_len_o, .tx_data_o, .tx_grant_i, .ctrl_rst_o,
    .rate_kbps_o, .clkout_o, .buscfg_o);

// ### test/can_node.sv
// Model of the other bus nodes: sends whole frames, grants the bus.
// Assumes one frame pulse per call and a grant seen for one edge.
module can_node (
    input wire logic clk_i,
    input wire logic [3:0] grant_wait_i,
    input wire logic req_i,
    input wire logic [28:0] req_id_i,
    input wire logic req_ext_i,
    input wire logic [3:0] req_len_i,
    input wire logic [63:0] req_data_i,
    output logic grant_o = 1'b0,
    output logic frm_valid_o = 1'b0,
    output logic [28:0] frm_id_o = 29'h0,
    output logic frm_ext_o = 1'b0,
    output logic [3:0] frm_len_o = 4'h0,
    output logic [63:0] frm_data_o = 64'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt = 0;
    int sent = 0;
    logic [28:0] seen_id = 29'h0;
    logic seen_ext = 1'b0;
    logic [3:0] seen_len = 4'h0;
    logic [63:0] seen_data = 64'h0;
    // Win arbitration after grant_wait_i cycles; record what went out
    always @(posedge clk_i) begin
        grant_o <= 1'b0;
        if (req_i && grant_o) begin
            sent <= sent + 1;
            seen_id <= req_id_i;
            seen_ext <= req_ext_i;
            seen_len <= req_len_i;
            seen_data <= req_data_i;
            wait_cnt <= 0;
        end else if (req_i) begin
            grant_o <= (wait_cnt >= int'(grant_wait_i));
            wait_cnt <= wait_cnt + 1;
        end
    end
    // One frame pulse; released lines show the inverse, not the old value
    task automatic put_frame(input logic [28:0] id, input logic ext, input logic [3:0] len, input logic [63:0] d);
        @(posedge clk_i);
        frm_valid_o <= 1'b1;
        frm_id_o <= id;
        frm_ext_o <= ext;
        frm_len_o <= len;
        frm_data_o <= d;
        @(posedge clk_i);
        frm_valid_o <= 1'b0;
        frm_id_o <= ~id;
        frm_ext_o <= ~ext;
        frm_len_o <= ~len;
        frm_data_o <= ~d;
    endtask
endmodule // can_node

// ### test/tb_top.sv
// Testbench of the CAN front end: bus tasks, one task per scenario.
// Assumes the front end, its checker and the node model compiled first.
`include "can_front_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [11:0] avs_address_i = 12'h000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [3:0] grant_wait = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, irq_o, rx_valid_i, rx_ext_i, tx_req_o, tx_ext_o, tx_grant_i, ctrl_rst_o;
    logic [28:0] rx_id_i, tx_id_o;
    logic [3:0] rx_len_i, tx_obj_o, tx_len_o;
    logic [63:0] rx_data_i, tx_data_o;
    logic [15:0] rate_kbps_o;
    logic [7:0] clkout_o, buscfg_o;
    int fails = 0;
    int tests_run = 0;

    always #2 clk_i = ~clk_i;

    can_front u_can_front (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .rx_valid_i, .rx_id_i, .rx_ext_i,
        .rx_len_i, .rx_data_i, .tx_req_o, .tx_obj_o, .tx_id_o, .tx_ext_o, .tx_len_o, .tx_data_o,
        .tx_grant_i, .ctrl_rst_o, .rate_kbps_o, .clkout_o, .buscfg_o);
    can_node u_can_node (.clk_i, .grant_wait_i(grant_wait), .req_i(tx_req_o), .req_id_i(tx_id_o),
        .req_ext_i(tx_ext_o), .req_len_i(tx_len_o), .req_data_i(tx_data_o), .grant_o(tx_grant_i),
        .frm_valid_o(rx_valid_i), .frm_id_o(rx_id_i), .frm_ext_o(rx_ext_i), .frm_len_o(rx_len_i),
        .frm_data_o(rx_data_i));

    task automatic conclude();
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Avalon cycle: held until waitrequest is sampled low, bounded wait
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 200);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 200) begin
            fails++;
            $display("mismatch at %0t: bus timeout", $time);
            conclude();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic cfg(input logic [3:0] obj, input logic [28:0] id, input logic [5:0] cmd);
        wr(`OFF_OBJ_SEL, {28'h0, obj});
        wr(`OFF_OBJ_ID, {3'h0, id});
        wr(`OFF_OBJ_CMD, {26'h0, cmd});
    endtask

    task automatic fetch(input logic [3:0] obj, output logic [31:0] q);
        wr(`OFF_OBJ_SEL, {28'h0, obj});
        rd(`OFF_FETCH, q);
    endtask

    // Second init must undo settings made after the first
    task automatic t_init();
        logic [31:0] q;
        wr(`OFF_CTRL, 32'h1);
        wr(`OFF_CLKOUT, 32'h5a);
        wr(`OFF_BUSCFG, 32'h33);
        wr(`OFF_FILTER, 32'h0);
        cfg(4'd1, 29'h28, 6'h03);
        check({24'h0, clkout_o}, 32'h5a);
        wr(`OFF_CTRL, 32'h1);
        rd(`OFF_BUSCFG, q);
        check(q, 32'h0);
        check({24'h0, clkout_o | buscfg_o}, 32'h0);
        check({16'h0, rate_kbps_o}, 32'd1000);
        rd(`OFF_FILTER, q);
        check(q, `FILTER_MUST_MATCH);
        wr(`OFF_OBJ_SEL, 32'h1);
        rd(`OFF_OBJ_CMD, q);
        check(q, 32'h0);
    endtask

    // Filtering, event, fetch once, buffer bytes, masking
    task automatic t_rx();
        logic [31:0] q;
        logic [63:0] d;
        d = 64'h0000_0000_db0f_4940;
        cfg(4'd2, 29'h50, 6'h04);
        cfg(4'd1, 29'h28, 6'h05);
        wr(`OFF_IRQ_MASK, 32'hffff);
        u_can_node.put_frame(29'h29, 1'b0, 4'd4, d);
        u_can_node.put_frame(29'h28, 1'b1, 4'd4, d);
        u_can_node.put_frame(29'h50, 1'b0, 4'd4, d);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        fetch(4'd2, q);
        check(q, `FETCH_NONE);
        fetch(4'd1, q);
        check(q, `FETCH_NONE);
        u_can_node.put_frame(29'h28, 1'b0, 4'd4, d);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        fetch(4'd1, q);
        check(q, 32'h28);
        for (int i = 1; i <= 4; i++) begin
            rd(12'(`OFF_BUF + 4 * i - 4), q);
            check(q, {24'h0, d[8 * i - 8 +: 8]});
        end
        rd(12'h060, q);
        check(q, 32'h4);
        fetch(4'd1, q);
        check(q, `FETCH_NONE);
        wr(`OFF_IRQ_STAT, 32'hffff);
        wr(`OFF_IRQ_MASK, 32'h0);
        check({31'h0, irq_o}, 32'h0);
        u_can_node.put_frame(29'h28, 1'b0, 4'd0, d);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        fetch(4'd1, q);
        check(q, 32'h28);
        rd(12'h060, q);
        check(q, 32'h0);
    endtask

    task automatic t_ext();
        logic [31:0] q;
        cfg(4'd3, 29'h1abc_def0, 6'h09);
        u_can_node.put_frame(29'h1abc_def0, 1'b1, 4'd8, 64'h0);
        fetch(4'd3, q);
        check(q, 32'h1abc_def0);
    endtask

    // Refused senders, then object 14 with a prompt and a slow grant
    task automatic t_tx();
        int s, n;
        s = u_can_node.sent;
        cfg(4'd6, 29'h28, 6'h10);
        cfg(4'd15, 29'h28, 6'h12);
        repeat (20) @(posedge clk_i);
        check(u_can_node.sent, s);
        cfg(4'd14, 29'h1fff_ffff, 6'h0a);
        for (int i = 1; i <= 9; i++) begin
            wr(12'(`OFF_BUF + 4 * i - 4), (i == 9) ? 32'h8 : 32'(8'h10 + i));
        end
        for (int k = 0; k < 2; k++) begin
            grant_wait <= 4'(5 * k);
            s = u_can_node.sent;
            wr(`OFF_OBJ_CMD, 32'h1a);
            n = 0;
            while (u_can_node.sent == s && n < 100) begin
                @(posedge clk_i);
                n++;
            end
            check(u_can_node.sent, s + 1);
            if (n >= 100) begin
                conclude();
            end
            check({3'h0, u_can_node.seen_id}, 32'h1fff_ffff);
            check({31'h0, u_can_node.seen_ext}, 32'h1);
            check({28'h0, tx_obj_o}, 32'he);
            check({28'h0, u_can_node.seen_len}, 32'h8);
            check(u_can_node.seen_data[63:32], 32'h1817_1615);
            check(u_can_node.seen_data[31:0], 32'h1413_1211);
        end
    endtask

    task automatic t_raw();
        logic [31:0] q;
        wr(12'h400, 32'ha5);
        wr(12'h7fc, 32'h5c);
        rd(12'h400, q);
        check(q, 32'ha5);
        rd(12'h7fc, q);
        check(q, 32'h5c);
        rd(12'h3f0, q);
        check(q, 32'h0);
    endtask

    // Reset for twelve cycles, then the scenarios in order
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_init();
        t_rx();
        t_ext();
        t_tx();
        t_raw();
        conclude();
    end
endmodule // tb_top
